// >>> design/sms_consts.svh
// Constants for the switch monitor supervisor: register map, field
// positions, reset values and timing counts.
// Assumes a 50 ns system clock and a 12-bit APB byte address.
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH

// Register word indices; byte address is four times the index
`define SMS_IDX_CONFIG   10'h000
`define SMS_IDX_CLEAN    10'h001
`define SMS_IDX_INTSTAT  10'h002
`define SMS_IDX_MISC     10'h003
`define SMS_IDX_SWCFG    10'h004
`define SMS_IDX_CRC      10'h005

// Configuration register fields
`define SMS_CFG_RUN      0
`define SMS_CFG_CRC      1
`define SMS_CFG_SWRST    2
`define SMS_CFG_FLD_LSB  4
`define SMS_CFG_FLD_MSB  7

// Interrupt status bits
`define SMS_INT_POR      0
`define SMS_INT_CHK      1
`define SMS_INT_LOW      2
`define SMS_INT_SWC      3

// Reset values
`define SMS_CFG_FLD_RST  4'h0
`define SMS_CLEAN_RST    8'h00
`define SMS_SWCFG_RST    8'h00
`define SMS_CRC_SEED     8'hff
`define SMS_CRC_POLY     8'h07
`define SMS_SYNC_RST     7'h04 // Chip select bit idles high, so no false edge

// Initialization time and its cycle count (least time, rounded up)
`define SMS_CLK_NS       50
`define SMS_INIT_NS      45000
`define SMS_INIT_CYC     ((`SMS_INIT_NS + `SMS_CLK_NS - 1) / `SMS_CLK_NS)

// Serial frame: address byte in, flag byte then data byte out
`define SMS_SPI_ABITS    8
`define SMS_SPI_BITS     16

`endif

// >>> design/sms_pkg.sv
// Types shared by the switch monitor supervisor.
// Assumes nothing beyond a SystemVerilog compiler.
package sms_pkg;

  // Supervisor states
  typedef enum logic [1:0] {
    SMS_OFF,
    SMS_INIT,
    SMS_CHECK,
    SMS_READY
  } sms_state_t;

endpackage : sms_pkg

// >>> design/sms_supervisor.sv
// Supervisor of a multi-input switch monitor: power-on init and
// self-check, run/stop lock of configuration, three reset sources,
// low-supply entry and recovery, serial status link, APB registers.
// Assumes supply comparators, reset pin and serial pins are
// asynchronous levels; polling engine and trim loader share clock_i.
//
// Behaviour
// - Hold in reset until supply is good, then load defaults and init.
// - After init pull interrupt low, set power-on bit and serial flag.
// - After trim load run self-check; on error flag it with power-on.
// - Host sets run bit; device then enables wetting current and monitoring.
// - While running only run, CRC, reset bits and clean-current take writes.
// - Clearing run stops wetting and monitoring and unlocks configuration.
// - CRC check stays usable while run bit is set.
// - Logic supply gone stops serial link but keeps registers.
// - Main supply below power-on level clears all and restarts init.
// - Reset pin high holds device in reset, link stopped, registers cleared.
// - Reset pin low again reinitializes, then interrupt and power-on flags.
// - Software reset bit reinitializes with defaults, then power-on flags.
// - Low supply entry stops all current sources and monitoring.
// - Low supply entry sets both low-supply bits, interrupt, other flag.
// - Chip select rise clears interrupt status only if it was read.
// - During low supply the link works and registers are kept.
// - No second entry interrupt while supply stays low.
// - Recovery raises interrupt, sets irq bit and clears level bit.
// - Recovery resumes monitoring and restarts polling from first input.
// - First poll after recovery raises change interrupt, sets baseline.
// - With interrupt pending a reset may take up to 1 ms.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sms_consts.svh"

module sms_supervisor
  import sms_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Supply comparators, reset pin, logic supply
  input  wire logic        por_ok_i,
  input  wire logic        uv_low_i,
  input  wire logic        reset_pin_i,
  input  wire logic        vdd_ok_i,
  // Serial status link
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        si_i,
  output logic             so_o,
  output logic             so_oen_o,
  output logic             int_n_o,
  // Trim loader and polling engine
  input  wire logic        trim_check_ok_i,
  input  wire logic        poll_cycle_done_i,
  output logic             wetting_en_o,
  output logic             monitor_en_o,
  output logic             poll_restart_o,
  output logic             baseline_load_o,
  output logic      [7:0]  clean_cfg_o,
  output logic      [7:0]  switch_cfg_o
);

  // Sampled copies of the asynchronous inputs
  logic [6:0]  sync1_q;
  logic [6:0]  sync2_q;
  logic        por_ok_s;
  logic        uv_s;
  logic        rst_pin_s;
  logic        vdd_s;
  logic        cs_n_s;
  logic        sclk_s;
  logic        si_s;
  logic        cs_n_q;
  logic        sclk_q;

  sms_state_t  state_q;
  logic [9:0]  init_cnt_q;

  // Register contents
  logic        run_q;
  logic [3:0]  cfg_fld_q;
  logic [7:0]  clean_cfg_reg_q;
  logic [7:0]  switch_cfg_q;
  logic [7:0]  crc_q;
  logic [3:0]  int_stat_q;
  logic [3:0]  int_stat_d;
  logic        low_supply_level_bit_q;
  logic        uv_prev_q;
  logic        first_poll_q;
  logic        monitor_q;
  logic        poll_restart_q;
  logic        baseline_q;

  // Serial link
  logic [4:0]  bit_cnt_q;
  logic [7:0]  addr_q;
  logic [7:0]  sh_q;
  logic        read_int_q;

  // APB answer
  logic [31:0] prdata_q;
  logic        pslverr_q;

  logic        ready;
  logic        link_on;
  logic        cs_fall;
  logic        cs_rise;
  logic        sclk_fall;
  logic        sclk_rise;
  logic        spi_clear;
  logic        apb_wr;
  logic [9:0]  apb_idx;
  logic        cfg_wr;
  logic        sw_rst_req;
  logic        crc_req;
  logic        uv_entry;
  logic        uv_exit;
  logic [7:0]  flags;
  logic [9:0]  link_idx;
  logic [31:0] link_word;

  // Word index is a valid register
  function automatic logic reg_hit(input logic [9:0] idx);
    reg_hit = (idx == `SMS_IDX_CONFIG) || (idx == `SMS_IDX_CLEAN) ||
              (idx == `SMS_IDX_INTSTAT) || (idx == `SMS_IDX_MISC) ||
              (idx == `SMS_IDX_SWCFG) || (idx == `SMS_IDX_CRC);
  endfunction : reg_hit

  // Read value of a register; shared by APB and the serial link
  function automatic logic [31:0] reg_word(input logic [9:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx == `SMS_IDX_CONFIG) begin
      w[`SMS_CFG_RUN] = run_q;
      w[`SMS_CFG_FLD_MSB:`SMS_CFG_FLD_LSB] = cfg_fld_q;
    end else if (idx == `SMS_IDX_CLEAN) begin
      w[7:0] = clean_cfg_reg_q;
    end else if (idx == `SMS_IDX_INTSTAT) begin
      w[3:0] = int_stat_q;
    end else if (idx == `SMS_IDX_MISC) begin
      w[0] = low_supply_level_bit_q;
      w[1] = monitor_q;
      w[2] = ready;
    end else if (idx == `SMS_IDX_SWCFG) begin
      w[7:0] = switch_cfg_q;
    end else if (idx == `SMS_IDX_CRC) begin
      w[7:0] = crc_q;
    end
    reg_word = w;
  endfunction : reg_word

  // CRC-8 over the settings, MSB first
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = `SMS_CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ `SMS_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc8 = c;
  endfunction : crc8

  // Two-flop synchronizers; only sync2_q is read by logic
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= `SMS_SYNC_RST;
      sync2_q <= `SMS_SYNC_RST;
    end else begin
      sync1_q <= {por_ok_i, uv_low_i, reset_pin_i, vdd_ok_i,
                  cs_n_i, sclk_i, si_i};
      sync2_q <= sync1_q;
    end
  end

  assign por_ok_s  = sync2_q[6];
  assign uv_s      = sync2_q[5];
  assign rst_pin_s = sync2_q[4];
  assign vdd_s     = sync2_q[3];
  assign cs_n_s    = sync2_q[2];
  assign sclk_s    = sync2_q[1];
  assign si_s      = sync2_q[0];

  // Edge history for chip select and serial clock
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_n_q <= cs_n_s;
      sclk_q <= sclk_s;
    end
  end

  assign ready     = (state_q == SMS_READY);
  assign link_on   = ready && vdd_s;
  assign cs_fall   = cs_n_q && !cs_n_s;
  assign cs_rise   = !cs_n_q && cs_n_s;
  assign sclk_fall = sclk_q && !sclk_s && !cs_n_s;
  assign sclk_rise = !sclk_q && sclk_s && !cs_n_s;

  // APB decode; zero wait states, writes act at the access edge
  assign apb_idx    = paddr_i[11:2];
  assign apb_wr     = psel_i && penable_i && pwrite_i && ready;
  assign cfg_wr     = apb_wr && (apb_idx == `SMS_IDX_CONFIG);
  assign sw_rst_req = cfg_wr && pwdata_i[`SMS_CFG_SWRST];
  assign crc_req    = cfg_wr && pwdata_i[`SMS_CFG_CRC];

  // Supply edges, only seen once the device is up
  assign uv_entry = ready && uv_s && !uv_prev_q;
  assign uv_exit  = ready && !uv_s && uv_prev_q;

  // Interrupt status is cleared by a serial frame that read it
  assign spi_clear = cs_rise && read_int_q && link_on;

  // Index as it stands once the current serial bit is in; feeds the data byte
  assign link_idx = {2'b00, addr_q[6:0], si_s};
  always_comb begin
    link_word = reg_word(link_idx);
  end

  // Supervisor sequence; a supply drop or reset pin overrides all
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q    <= SMS_OFF;
      init_cnt_q <= 10'h000;
    end else if (!por_ok_s || rst_pin_s) begin
      state_q    <= SMS_OFF;
      init_cnt_q <= 10'h000;
    end else begin
      case (state_q)
        SMS_OFF: begin
          state_q    <= SMS_INIT;
          init_cnt_q <= 10'h000;
        end
        SMS_INIT: begin
          init_cnt_q <= init_cnt_q + 10'h001;
          if (init_cnt_q == 10'(`SMS_INIT_CYC - 1)) begin
            state_q <= SMS_CHECK;
          end
        end
        SMS_CHECK: begin
          state_q <= SMS_READY;
        end
        SMS_READY: begin
          if (sw_rst_req) begin
            state_q    <= SMS_INIT;
            init_cnt_q <= 10'h000;
          end
        end
        default: begin
          state_q <= SMS_OFF;
        end
      endcase
    end
  end

  // Configuration; defaults held until ready, field and switch config locked while running
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_q           <= 1'b0;
      cfg_fld_q       <= `SMS_CFG_FLD_RST;
      clean_cfg_reg_q <= `SMS_CLEAN_RST;
      switch_cfg_q    <= `SMS_SWCFG_RST;
    end else if (!ready || sw_rst_req) begin
      run_q           <= 1'b0;
      cfg_fld_q       <= `SMS_CFG_FLD_RST;
      clean_cfg_reg_q <= `SMS_CLEAN_RST;
      switch_cfg_q    <= `SMS_SWCFG_RST;
    end else if (apb_wr) begin
      if (apb_idx == `SMS_IDX_CONFIG) begin
        run_q <= pwdata_i[`SMS_CFG_RUN];
        if (!run_q) begin
          cfg_fld_q <= pwdata_i[`SMS_CFG_FLD_MSB:`SMS_CFG_FLD_LSB];
        end
      end else if (apb_idx == `SMS_IDX_CLEAN) begin
        clean_cfg_reg_q <= pwdata_i[7:0];
      end else if (apb_idx == `SMS_IDX_SWCFG) begin
        if (!run_q) begin
          switch_cfg_q <= pwdata_i[7:0];
        end
      end
    end
  end

  // Settings check, open whatever the run bit
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      crc_q <= 8'h00;
    end else if (!ready) begin
      crc_q <= 8'h00;
    end else if (crc_req) begin
      crc_q <= crc8({8'h00, switch_cfg_q, cfg_fld_q, 4'h0} ^
                    {16'h0000, clean_cfg_reg_q});
    end
  end

  // Interrupt status next value; a set in the clearing cycle wins
  always_comb begin
    int_stat_d = int_stat_q;
    if (state_q == SMS_OFF || state_q == SMS_INIT) begin
      int_stat_d = 4'h0;
    end else if (state_q == SMS_CHECK) begin
      int_stat_d[`SMS_INT_POR] = 1'b1;
      int_stat_d[`SMS_INT_CHK] = !trim_check_ok_i;
    end else begin
      if (spi_clear) begin
        int_stat_d = 4'h0;
      end
      if (uv_entry || uv_exit) begin
        int_stat_d[`SMS_INT_LOW] = 1'b1;
      end
      if (first_poll_q && poll_cycle_done_i) begin
        int_stat_d[`SMS_INT_SWC] = 1'b1;
      end
    end
  end

  // Interrupt status register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_stat_q <= 4'h0;
    end else begin
      int_stat_q <= int_stat_d;
    end
  end

  // Low-supply level tracking; other registers are left alone
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uv_prev_q              <= 1'b0;
      low_supply_level_bit_q <= 1'b0;
    end else if (!ready) begin
      uv_prev_q              <= 1'b0;
      low_supply_level_bit_q <= 1'b0;
    end else begin
      uv_prev_q              <= uv_s;
      low_supply_level_bit_q <= uv_s;
    end
  end

  // Wetting and monitoring; stopped by low supply or run cleared
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      monitor_q <= 1'b0;
    end else begin
      monitor_q <= ready && run_q && !sw_rst_req && !uv_s;
    end
  end

  // Recovery: restart polling, then first full cycle sets baseline
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      poll_restart_q <= 1'b0;
      first_poll_q   <= 1'b0;
      baseline_q     <= 1'b0;
    end else begin
      poll_restart_q <= uv_exit;
      baseline_q     <= first_poll_q && poll_cycle_done_i;
      if (!ready || uv_s) begin
        first_poll_q <= 1'b0;
      end else if (uv_exit) begin
        first_poll_q <= 1'b1;
      end else if (poll_cycle_done_i) begin
        first_poll_q <= 1'b0;
      end
    end
  end

  // Flag byte sent first in every frame
  assign flags = {int_stat_q[`SMS_INT_POR],
                  low_supply_level_bit_q || int_stat_q[`SMS_INT_LOW],
                  int_stat_q[`SMS_INT_SWC],
                  int_stat_q[`SMS_INT_CHK],
                  4'h0};

  // Serial link: sample on falling clock, shift out on rising
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt_q  <= 5'h00;
      addr_q     <= 8'h00;
      sh_q       <= 8'h00;
      read_int_q <= 1'b0;
    end else if (!link_on) begin
      bit_cnt_q  <= 5'h00;
      read_int_q <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_q  <= 5'h00;
      addr_q     <= 8'h00;
      sh_q       <= flags;
      read_int_q <= 1'b0;
    end else if (sclk_fall && bit_cnt_q < 5'(`SMS_SPI_BITS)) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      if (bit_cnt_q < 5'(`SMS_SPI_ABITS)) begin
        addr_q <= {addr_q[6:0], si_s};
      end
      // Data byte loaded as the index completes, so it leads the next rise
      if (bit_cnt_q == 5'(`SMS_SPI_ABITS - 1)) begin
        sh_q <= link_word[7:0];
      end
      if (bit_cnt_q == 5'(`SMS_SPI_BITS - 1) &&
          {2'b00, addr_q} == `SMS_IDX_INTSTAT) begin
        read_int_q <= 1'b1;
      end
    end else if (sclk_rise) begin
      sh_q <= {sh_q[6:0], 1'b0};
    end
  end

  // APB read data and error captured in the setup phase
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_q  <= reg_hit(apb_idx) ? reg_word(apb_idx) : 32'h0000_0000;
      pslverr_q <= !reg_hit(apb_idx);
    end
  end

  assign prdata_o        = prdata_q;
  assign pready_o        = 1'b1;
  assign pslverr_o       = pslverr_q && psel_i && penable_i;
  // Interrupt low while any status bit stands
  assign int_n_o         = !(|int_stat_q);
  assign so_o            = sh_q[7];
  assign so_oen_o        = !(link_on && !cs_n_s);
  assign wetting_en_o    = monitor_q;
  assign monitor_en_o    = monitor_q;
  assign poll_restart_o  = poll_restart_q;
  assign baseline_load_o = baseline_q;
  assign clean_cfg_o     = clean_cfg_reg_q;
  assign switch_cfg_o    = switch_cfg_q;

endmodule : sms_supervisor
`default_nettype wire

// >>> tb/sms_host_model.sv
// Host model: serial frames at a 400 ns bit clock and the reset pin.
// Assumes clock_i is the system clock; all changes follow its rising edge.
`timescale 1ns/10ps
`default_nettype none

module sms_host_model (
  input  wire logic clock_i,
  input  wire logic so_i,
  input  wire logic so_oen_i,
  output var logic  cs_n_o = 1'b1,
  output var logic  sclk_o = 1'b0,
  output var logic  si_o = 1'b0,
  output var logic  reset_pin_o = 1'b0
);
  logic so_w;

  // A released output sinks low through its load
  assign so_w = so_oen_i ? 1'b0 : so_i;

  // One 16-bit frame, index out MSB first, data sampled before each rise
  task automatic frame(input logic [7:0] idx, output logic [15:0] rx);
    logic [15:0] tx;
    tx = {idx, 8'h00};
    cs_n_o <= 1'b0;
    repeat (8) @(posedge clock_i);
    for (int k = 15; k >= 0; k--) begin
      @(posedge clock_i);
      rx[k] = so_w; // Taken at the edge that raises the clock
      sclk_o <= 1'b1;
      si_o   <= tx[k];
      repeat (4) @(posedge clock_i);
      sclk_o <= 1'b0;
      repeat (3) @(posedge clock_i);
    end
    repeat (4) @(posedge clock_i);
    cs_n_o <= 1'b1;
    si_o   <= ~si_o; // Data line no longer holds its last bit
    repeat (40) @(posedge clock_i);
  endtask : frame

  // Pulse of 3 us, above the 2 us minimum
  task automatic pin_reset;
    reset_pin_o <= 1'b1;
    repeat (60) @(posedge clock_i);
    reset_pin_o <= 1'b0;
    @(posedge clock_i);
  endtask : pin_reset
endmodule : sms_host_model

`default_nettype wire

// >>> tb/sms_supervisor_bench.sv
// Bench for the switch monitor supervisor: self-check and software reset,
// then APB rows, low supply, serial link, pin reset and supply reset cases.
// Assumes the checker bind and the host model are compiled with it.
`timescale 1ns/10ps
`default_nettype none

module sms_supervisor_bench;
  typedef struct {
    logic [11:0] a;
    logic [7:0]  w;
    logic [7:0]  r;
    logic        m;
    logic        e;
  } sms_row_t;

  logic        clock_i, pready, pslverr, so, so_oen, int_n, wetting_en, monitor_en;
  logic        rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic        por_ok = 1'b1, uv_low = 1'b0, vdd_ok = 1'b1, trim_ok = 1'b0;
  logic        poll_done = 1'b0, cs_n, sclk, si, reset_pin;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] rx;
  logic [7:0]  clean_cfg, switch_cfg;
  int          num_errors = 0, cmp_count = 0;
  // Write, then read back; run bit locks the field and switch cfg
  sms_row_t    rows [12] = '{
    '{12'h004, 8'h5a, 8'h5a, 1'b0, 1'b0}, '{12'h010, 8'h3c, 8'h3c, 1'b0, 1'b0},
    '{12'h000, 8'ha0, 8'ha0, 1'b0, 1'b0}, '{12'h000, 8'ha1, 8'ha1, 1'b1, 1'b0},
    '{12'h000, 8'h51, 8'ha1, 1'b1, 1'b0}, '{12'h010, 8'h11, 8'h3c, 1'b1, 1'b0},
    '{12'h004, 8'h77, 8'h77, 1'b1, 1'b0}, '{12'h000, 8'ha3, 8'ha1, 1'b1, 1'b0},
    '{12'h000, 8'ha0, 8'ha0, 1'b0, 1'b0}, '{12'h010, 8'h11, 8'h11, 1'b0, 1'b0},
    '{12'h000, 8'h51, 8'h51, 1'b1, 1'b0}, '{12'h040, 8'hff, 8'h00, 1'b1, 1'b1}};

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  sms_supervisor i_sms_supervisor (
    .clock_i(clock_i), .rstn_i(rstn_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .por_ok_i(por_ok), .uv_low_i(uv_low),
    .reset_pin_i(reset_pin), .vdd_ok_i(vdd_ok), .cs_n_i(cs_n), .sclk_i(sclk),
    .si_i(si), .so_o(so), .so_oen_o(so_oen), .int_n_o(int_n),
    .trim_check_ok_i(trim_ok), .poll_cycle_done_i(poll_done),
    .wetting_en_o(wetting_en), .monitor_en_o(monitor_en), .poll_restart_o(),
    .baseline_load_o(), .clean_cfg_o(clean_cfg), .switch_cfg_o(switch_cfg));

  sms_host_model i_sms_host_model (
    .clock_i(clock_i), .so_i(so), .so_oen_i(so_oen), .cs_n_o(cs_n),
    .sclk_o(sclk), .si_o(si), .reset_pin_o(reset_pin));

  task automatic summarize;
    $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic give_up;
    num_errors++;
    summarize();
  endtask : give_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; answer taken from the values standing at the edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    logic rdy;
    int   n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      rdy = pready; // Answer taken at the edge that samples pready
      rd  = prdata;
      err = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) give_up();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask : apb

  // Poll the ready bit; init takes about 900 cycles
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h00c, 32'h0);
      n++;
    end while (rd[2] !== 1'b1 && n < 1000);
    if (rd[2] !== 1'b1) give_up();
  endtask : wait_ready

  initial begin
    repeat (5) @(posedge clock_i);
    rstn_i <= 1'b1;
    wait_ready();
    chk(int_n, 1'b0);
    i_sms_host_model.frame(8'h02, rx);
    chk(rx, 16'h9003);
    chk(int_n, 1'b1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, (i == 3) ? 32'h00000004 : 32'h0);
    end
    trim_ok <= 1'b1;
    apb(1'b1, 12'h000, 32'h00000004);
    wait_ready();
    i_sms_host_model.frame(8'h02, rx);
    chk(rx, 16'h8001);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, {24'h0, rows[i].w});
      chk(err, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      if (!rows[i].e) chk(rd, {24'h0, rows[i].r});
      chk(monitor_en, rows[i].m);
      chk(wetting_en, rows[i].m);
    end
    // Check taken with run set over switch 3c, field a, clean 77
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h00000005);
    chk(clean_cfg, 8'h77);
    chk(switch_cfg, 8'h11);
    // Low supply while running, then recovery and first poll
    uv_low <= 1'b1;
    repeat (8) @(posedge clock_i);
    chk(wetting_en, 1'b0);
    chk(int_n, 1'b0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h00000005);
    i_sms_host_model.frame(8'h01, rx);
    chk(rx, 16'h4077);
    i_sms_host_model.frame(8'h02, rx);
    chk(rx, 16'h4004);
    repeat (20) @(posedge clock_i);
    chk(int_n, 1'b1);
    uv_low <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk(int_n, 1'b0);
    chk(monitor_en, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h00000006);
    poll_done <= 1'b1;
    @(posedge clock_i);
    poll_done <= 1'b0;
    i_sms_host_model.frame(8'h02, rx);
    chk(rx, 16'h600c);
    // Logic supply gone: link silent, registers kept
    vdd_ok <= 1'b0;
    repeat (4) @(posedge clock_i);
    i_sms_host_model.frame(8'h01, rx);
    chk(rx, 16'h0000);
    vdd_ok <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h00000077);
    i_sms_host_model.pin_reset();
    wait_ready();
    chk(int_n, 1'b0);
    i_sms_host_model.frame(8'h02, rx);
    chk(rx, 16'h8001);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h004, 32'h00000033);
    por_ok <= 1'b0;
    repeat (10) @(posedge clock_i);
    chk(int_n, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    por_ok <= 1'b1;
    wait_ready();
    chk(int_n, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    summarize();
  end
endmodule : sms_supervisor_bench

`default_nettype wire

// >>> tb/sms_supervisor_checker.sv
// Checker for the switch monitor supervisor, bound to its ports.
// Assumes clock_i is the only clock and rstn_i its async reset.
`timescale 1ns/10ps
`default_nettype none

module sms_supervisor_checker (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic uv_low_i,
  input wire logic reset_pin_i,
  input wire logic vdd_ok_i,
  input wire logic so_oen_o,
  input wire logic int_n_o,
  input wire logic poll_cycle_done_i,
  input wire logic wetting_en_o,
  input wire logic monitor_en_o,
  input wire logic poll_restart_o,
  input wire logic baseline_load_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  // Supply crossings; the bench only moves the supply while ready
  sequence uv_enter_s;
    $rose(uv_low_i);
  endsequence
  sequence uv_leave_s;
    $fell(uv_low_i);
  endsequence

  // A split enable would leave a source on without monitoring
  enable_pair_a: assert property (wetting_en_o == monitor_en_o)
    else $error("wetting and monitor enables differ");
  uv_stop_a: assert property (uv_enter_s |-> ##[1:6] !wetting_en_o)
    else $error("sources still on after low supply");
  uv_irq_a: assert property (uv_enter_s |-> ##[2:6] !int_n_o)
    else $error("no interrupt on low supply entry");
  uv_restart_a: assert property (uv_leave_s |-> ##[2:6] poll_restart_o)
    else $error("polling not restarted on recovery");
  recover_irq_a: assert property (poll_restart_o |-> ##[0:2] !int_n_o)
    else $error("no interrupt on recovery");
  baseline_cause_a: assert property (baseline_load_o |-> $past(poll_cycle_done_i))
    else $error("baseline load without a finished poll");
  pin_reset_a: assert property (reset_pin_i [*6] |->
      so_oen_o && int_n_o && !monitor_en_o)
    else $error("device active while reset pin high");
  vdd_link_a: assert property (!vdd_ok_i [*6] |-> so_oen_o)
    else $error("serial output driven without logic supply");
endmodule : sms_supervisor_checker

bind sms_supervisor sms_supervisor_checker i_sms_supervisor_checker (
  .clock_i, .rstn_i, .uv_low_i, .reset_pin_i, .vdd_ok_i, .so_oen_o, .int_n_o,
  .poll_cycle_done_i, .wetting_en_o, .monitor_en_o, .poll_restart_o, .baseline_load_o
);

`default_nettype wire
